/* itsdc_consts.svh */
// Constants for the translation-service command interpreter
`ifndef ITSDC_CONSTS_SVH
`define ITSDC_CONSTS_SVH
`define ITSDC_PKT_BYTES       32
`define ITSDC_OPC_LSB         0
`define ITSDC_OPC_MSB         7
`define ITSDC_OPC_DROP        8'h0F
`define ITSDC_OPC_PEND        8'h03
`define ITSDC_OPC_EVREF       8'h0C
`define ITSDC_OPC_COLREF      8'h0D
`define ITSDC_DEV_LSB         32
`define ITSDC_DEV_MSB         63
`define ITSDC_EVT_LSB         0
`define ITSDC_EVT_MSB         31
`define ITSDC_COL_LSB         0
`define ITSDC_COL_MSB         15
`define ITSDC_PTR_RESET       16'h0000
`endif

/* itsdc_pkg.sv */
// Types shared by both ends of the command interpreter link
package itsdc_pkg;
   typedef enum logic [1:0] {
      ITSDC_TBL_DEVICE,
      ITSDC_TBL_TRANS,
      ITSDC_TBL_COLL,
      ITSDC_TBL_TRANS_WR
   } itsdc_tbl_t;
   typedef enum logic [2:0] {
      ITSDC_RD_NONE,
      ITSDC_RD_CLEAR,
      ITSDC_RD_SET,
      ITSDC_RD_INV_EVENT,
      ITSDC_RD_INV_COLL
   } itsdc_rdop_t;
   typedef enum logic [1:0] {
      ITSDC_ERR_IGNORE,
      ITSDC_ERR_STALL,
      ITSDC_ERR_EXECUTE
   } itsdc_errmode_t;
endpackage

/* itsdc_if.sv */
// Link between the command interpreter and the table memory / redistributor side
`timescale 1ns/1ps
interface itsdc_if;
   // Table access
   logic                     tbl_req;
   itsdc_pkg::itsdc_tbl_t    tbl_kind;
   logic [31:0]              tbl_index;
   logic [31:0]              tbl_base;
   logic                     tbl_ack;
   logic                     tbl_valid;
   logic [4:0]               tbl_size;
   logic [31:0]              tbl_base_out;
   logic [15:0]              tbl_coll;
   logic                     tbl_virtual;
   // Redistributor request
   logic                     rd_req;
   itsdc_pkg::itsdc_rdop_t   rd_op;
   logic [15:0]              rd_coll;
   logic [31:0]              rd_intid;
   logic                     rd_ack;
   logic                     rd_ok;
   modport dev  (output tbl_req, tbl_kind, tbl_index, tbl_base, rd_req, rd_op, rd_coll, rd_intid,
                 input tbl_ack, tbl_valid, tbl_size, tbl_base_out, tbl_coll, tbl_virtual, rd_ack, rd_ok);
   modport far  (input tbl_req, tbl_kind, tbl_index, tbl_base, rd_req, rd_op, rd_coll, rd_intid,
                 output tbl_ack, tbl_valid, tbl_size, tbl_base_out, tbl_coll, tbl_virtual, rd_ack, rd_ok);
endinterface

/* itsdc_cmd_exec.sv */
// Command interpreter: drop, set-pending, event refresh and collection refresh
`timescale 1ns/1ps
`include "itsdc_consts.svh"
//
// What this block does
// R1 - Packet is four doublewords, opcode byte zero
// R2 - Drop code 0x0F, device high, event low
// R3 - Drop clears pending at target redistributor
// R4 - Drop also refreshes that event's caches
// R5 - Drop writes translation entry back invalid
// R6 - Set-pending code 0x03, same field layout
// R7 - Set-pending marks interrupt pending at target
// R8 - Event refresh code 0x0C, same layout
// R9 - Event refresh identical for physical, virtual
// R10 - Collection refresh code 0x0D, collection in dw2
// R11 - Collection refresh invalidates whole collection everywhere
// R12 - Device identifier above maximum is error
// R13 - Invalid device-table entry is error
// R14 - Event beyond table size is error
// R15 - Invalid translation entry error; drop still writes
// R16 - Unmapped collection target is error
// R17 - Unmapped virtual processor on refresh is error
// R18 - Bad or unmapped collection on refresh error
// R19 - System error pulse when capable and erring
// R20 - Advance read pointer, wrapping at queue end
// R21 - On error, ignore-and-advance or execute anyway; here execute mode stops at the fault and advances like ignore
// R22 - Or stall, flag set, until retry
// R23 - Strictly in-order, one command at once
module itsdc_cmd_exec #(
   parameter int DEV_BITS  = 16,
   parameter int COL_BITS  = 8,
   parameter int PTR_BITS  = 16
) (
   // Clock and reset
   input  wire logic                  REF_CLK,
   input  wire logic                  RST_N,
   // Queue and command
   input  wire logic                  CMD_VALID,
   input  wire logic [255:0]          CMD_PACKET,
   input  wire logic [PTR_BITS-1:0]   QUEUE_ENTRIES,
   output logic                       CMD_TAKEN,
   output logic [PTR_BITS-1:0]        QUEUE_READ_POINTER,
   output logic                       STALLED,
   // Configuration
   input  wire logic                  SYSTEM_ERROR_CAPABLE,
   input  wire itsdc_pkg::itsdc_errmode_t ERR_MODE,
   input  wire logic                  RETRY,
   output logic                       SYSTEM_ERROR,
   output logic                       BUSY,
   // Far side
   itsdc_if.dev                       link
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_DEV, ST_TRANS, ST_COLL, ST_REDIST, ST_WRBACK, ST_DONE, ST_STALL
   } itsdc_state_t;

   itsdc_state_t              state;
   itsdc_state_t              next_state;
   logic [7:0]                opc;
   logic [7:0]                next_opc;
   logic [31:0]               dev_id;
   logic [31:0]               next_dev_id;
   logic [31:0]               evt_id;
   logic [31:0]               next_evt_id;
   logic [15:0]               col_id;
   logic [15:0]               next_col_id;
   logic [31:0]               tt_base;
   logic [31:0]               next_tt_base;
   logic                      err;
   logic                      next_err;
   logic                      tbl_req;
   logic                      next_tbl_req;
   itsdc_pkg::itsdc_tbl_t     tbl_kind;
   itsdc_pkg::itsdc_tbl_t     next_tbl_kind;
   logic [31:0]               tbl_index;
   logic [31:0]               next_tbl_index;
   logic                      rd_req;
   logic                      next_rd_req;
   itsdc_pkg::itsdc_rdop_t    rd_op;
   itsdc_pkg::itsdc_rdop_t    next_rd_op;
   logic [31:0]               rd_intid;
   logic [31:0]               next_rd_intid;
   logic [PTR_BITS-1:0]       next_ptr;
   logic                      next_taken;
   logic                      next_stalled;
   logic                      next_serr;

   // Event beyond 2^(size+1) entries
   function automatic logic evt_oor(input logic [31:0] e, input logic [4:0] sz);
      logic [5:0] bits;
      bits = {1'b0, sz} + 6'd1;
      evt_oor = (bits < 6'd32) && ((e >> bits) != 32'h0000_0000);
   endfunction

   function automatic logic known_opc(input logic [7:0] o);
      known_opc = (o == `ITSDC_OPC_DROP) || (o == `ITSDC_OPC_PEND) ||
                  (o == `ITSDC_OPC_EVREF) || (o == `ITSDC_OPC_COLREF); // [R2] [R6] [R8] [R10]
   endfunction

   assign link.tbl_req   = tbl_req;
   assign link.tbl_kind  = tbl_kind;
   assign link.tbl_index = tbl_index;
   assign link.tbl_base  = tt_base;
   assign link.rd_req    = rd_req;
   assign link.rd_op     = rd_op;
   assign link.rd_coll   = col_id;
   assign link.rd_intid  = rd_intid;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_state    = state;
      next_opc      = opc;
      next_dev_id   = dev_id;
      next_evt_id   = evt_id;
      next_col_id   = col_id;
      next_tt_base  = tt_base;
      next_err      = err;
      next_tbl_req  = 1'b0;
      next_tbl_kind = tbl_kind;
      next_tbl_index = tbl_index;
      next_rd_req   = 1'b0;
      next_rd_op    = rd_op;
      next_rd_intid = rd_intid;
      next_ptr      = QUEUE_READ_POINTER;
      next_taken    = 1'b0;
      next_stalled  = STALLED;
      next_serr     = 1'b0;
      case (state)
         ST_IDLE:
         begin
            if (CMD_VALID)
            begin
               // Unknown codes belong to other units; they are simply skipped
               next_opc    = CMD_PACKET[`ITSDC_OPC_MSB:`ITSDC_OPC_LSB]; // [R1]
               next_dev_id = CMD_PACKET[`ITSDC_DEV_MSB:`ITSDC_DEV_LSB]; // [R2] [R6] [R8]
               next_evt_id = CMD_PACKET[64+`ITSDC_EVT_MSB:64+`ITSDC_EVT_LSB];
               next_col_id = CMD_PACKET[128+`ITSDC_COL_MSB:128+`ITSDC_COL_LSB]; // [R10]
               next_err    = 1'b0;
               if (!known_opc(CMD_PACKET[`ITSDC_OPC_MSB:`ITSDC_OPC_LSB]))
                  next_state = ST_DONE;
               else if (CMD_PACKET[`ITSDC_OPC_MSB:`ITSDC_OPC_LSB] == `ITSDC_OPC_COLREF)
               begin
                  if ((CMD_PACKET[128+`ITSDC_COL_MSB:128+`ITSDC_COL_LSB] >> COL_BITS) != 16'h0000)
                  begin
                     next_err   = 1'b1; // [R18]
                     next_state = ST_DONE;
                  end
                  else
                  begin
                     next_tbl_req   = 1'b1;
                     next_tbl_kind  = itsdc_pkg::ITSDC_TBL_COLL;
                     next_tbl_index = {16'h0000, CMD_PACKET[128+`ITSDC_COL_MSB:128+`ITSDC_COL_LSB]};
                     next_state     = ST_COLL;
                  end
               end
               else if ((CMD_PACKET[`ITSDC_DEV_MSB:`ITSDC_DEV_LSB] >> DEV_BITS) != 32'h0000_0000)
               begin
                  next_err   = 1'b1; // [R12]
                  next_state = ST_DONE;
               end
               else
               begin
                  next_tbl_req   = 1'b1;
                  next_tbl_kind  = itsdc_pkg::ITSDC_TBL_DEVICE;
                  next_tbl_index = CMD_PACKET[`ITSDC_DEV_MSB:`ITSDC_DEV_LSB];
                  next_state     = ST_DEV;
               end
            end
         end
         ST_DEV:
         begin
            if (link.tbl_ack)
            begin
               next_tt_base = link.tbl_base_out;
               if (!link.tbl_valid || evt_oor(evt_id, link.tbl_size))
               begin
                  next_err   = 1'b1; // [R13] [R14]
                  next_state = ST_DONE;
               end
               else
               begin
                  next_tbl_req   = 1'b1;
                  next_tbl_kind  = itsdc_pkg::ITSDC_TBL_TRANS;
                  next_tbl_index = evt_id;
                  next_state     = ST_TRANS;
               end
            end
         end
         ST_TRANS:
         begin
            if (link.tbl_ack)
            begin
               next_col_id   = link.tbl_coll;
               next_rd_intid = link.tbl_base_out;
               if (!link.tbl_valid)
               begin
                  next_err   = 1'b1; // [R15]
                  next_state = (opc == `ITSDC_OPC_DROP) ? ST_WRBACK : ST_DONE;
                  next_tbl_req   = (opc == `ITSDC_OPC_DROP);
                  next_tbl_kind  = itsdc_pkg::ITSDC_TBL_TRANS_WR;
               end
               else
               begin
                  // Same request whether physical or virtual target
                  next_rd_req = 1'b1; // [R9]
                  next_rd_op  = (opc == `ITSDC_OPC_DROP) ? itsdc_pkg::ITSDC_RD_CLEAR : // [R3] [R4]
                                (opc == `ITSDC_OPC_PEND) ? itsdc_pkg::ITSDC_RD_SET : // [R7]
                                itsdc_pkg::ITSDC_RD_INV_EVENT;
                  next_state  = ST_REDIST;
               end
            end
         end
         ST_COLL:
         begin
            if (link.tbl_ack)
            begin
               if (!link.tbl_valid)
               begin
                  next_err   = 1'b1; // [R18]
                  next_state = ST_DONE;
               end
               else
               begin
                  next_rd_req = 1'b1;
                  next_rd_op  = itsdc_pkg::ITSDC_RD_INV_COLL; // [R11]
                  next_state  = ST_REDIST;
               end
            end
         end
         ST_REDIST:
         begin
            if (link.rd_ack)
            begin
               if (!link.rd_ok)
                  next_err = 1'b1; // [R16] [R17]
               if (opc == `ITSDC_OPC_DROP)
               begin
                  next_tbl_req  = 1'b1;
                  next_tbl_kind = itsdc_pkg::ITSDC_TBL_TRANS_WR; // [R5]
                  next_state    = ST_WRBACK;
               end
               else
                  next_state = ST_DONE;
            end
         end
         ST_WRBACK:
         begin
            if (link.tbl_ack)
               next_state = ST_DONE; // [R15]
         end
         ST_DONE:
         begin
            next_serr = err && SYSTEM_ERROR_CAPABLE; // [R19]
            if (err && ERR_MODE == itsdc_pkg::ITSDC_ERR_STALL)
            begin
               next_stalled = 1'b1; // [R22]
               next_state   = ST_STALL;
            end
            else
            begin
               // Ignore and execute both advance; execution already ran up to the fault
               next_taken = 1'b1; // [R21] [R23]
               next_ptr   = (QUEUE_READ_POINTER + 1'b1 >= QUEUE_ENTRIES) ? PTR_BITS'(`ITSDC_PTR_RESET) :
                            PTR_BITS'(QUEUE_READ_POINTER + 1'b1); // [R20]
               next_state = ST_IDLE;
            end
         end
         ST_STALL:
         begin
            if (RETRY)
            begin
               next_stalled = 1'b0; // [R22]
               next_state   = ST_IDLE;
            end
         end
         default:
            next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         state              <= ST_IDLE;
         opc                <= 8'h00;
         dev_id             <= 32'h0000_0000;
         evt_id             <= 32'h0000_0000;
         col_id             <= 16'h0000;
         tt_base            <= 32'h0000_0000;
         err                <= 1'b0;
         tbl_req            <= 1'b0;
         tbl_kind           <= itsdc_pkg::ITSDC_TBL_DEVICE;
         tbl_index          <= 32'h0000_0000;
         rd_req             <= 1'b0;
         rd_op              <= itsdc_pkg::ITSDC_RD_NONE;
         rd_intid           <= 32'h0000_0000;
         QUEUE_READ_POINTER <= PTR_BITS'(`ITSDC_PTR_RESET);
         CMD_TAKEN          <= 1'b0;
         STALLED            <= 1'b0;
         SYSTEM_ERROR       <= 1'b0;
         BUSY               <= 1'b0;
      end
      else
      begin
         state              <= next_state;
         opc                <= next_opc;
         dev_id             <= next_dev_id;
         evt_id             <= next_evt_id;
         col_id             <= next_col_id;
         tt_base            <= next_tt_base;
         err                <= next_err;
         tbl_req            <= next_tbl_req;
         tbl_kind           <= next_tbl_kind;
         tbl_index          <= next_tbl_index;
         rd_req             <= next_rd_req;
         rd_op              <= next_rd_op;
         rd_intid           <= next_rd_intid;
         QUEUE_READ_POINTER <= next_ptr;
         CMD_TAKEN          <= next_taken;
         STALLED            <= next_stalled;
         SYSTEM_ERROR       <= next_serr;
         BUSY               <= (next_state != ST_IDLE); // [R23]
      end
   end
endmodule

/* itsdc_far_end.sv */
// Far end: answers table reads and redistributor requests from a user-side port
`timescale 1ns/1ps
module itsdc_far_end (
   // Clock and reset
   input  wire logic          REF_CLK,
   input  wire logic          RST_N,
   // User side: table answer
   input  wire logic          TBL_VALID,
   input  wire logic [4:0]    TBL_SIZE,
   input  wire logic [31:0]   TBL_DATA,
   input  wire logic [15:0]   TBL_COLL,
   input  wire logic          TBL_VIRTUAL,
   input  wire logic          TARGET_MAPPED,
   // User side: observed requests
   output logic               TBL_SEEN,
   output logic               RD_SEEN,
   output logic [2:0]         RD_OP_SEEN,
   // Link
   itsdc_if.far               link
);
   logic   next_tbl_ack;
   logic   next_rd_ack;
   logic   tbl_ack;
   logic   rd_ack;

   assign link.tbl_ack      = tbl_ack;
   assign link.rd_ack       = rd_ack;
   assign link.tbl_valid    = TBL_VALID;
   assign link.tbl_size     = TBL_SIZE;
   assign link.tbl_base_out = TBL_DATA;
   assign link.tbl_coll     = TBL_COLL;
   assign link.tbl_virtual  = TBL_VIRTUAL;
   // Target mapping covers collection and virtual processor alike
   assign link.rd_ok        = TARGET_MAPPED; // [R16] [R17]

   ////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_tbl_ack = link.tbl_req; // Every table request answered on the next cycle
      next_rd_ack  = link.rd_req;
   end

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         tbl_ack    <= 1'b0;
         rd_ack     <= 1'b0;
         TBL_SEEN   <= 1'b0;
         RD_SEEN    <= 1'b0;
         RD_OP_SEEN <= 3'h0;
      end
      else
      begin
         tbl_ack    <= next_tbl_ack;
         rd_ack     <= next_rd_ack;
         TBL_SEEN   <= next_tbl_ack;
         RD_SEEN    <= next_rd_ack;
         RD_OP_SEEN <= link.rd_req ? 3'(link.rd_op) : RD_OP_SEEN;
      end
   end
endmodule

/* itsdc_link_props.sv */
// Link checks between the command interpreter and its far end
`timescale 1ns/1ps
module itsdc_link_props (
   // Clock and reset
   input wire logic                   REF_CLK,
   input wire logic                   RST_N,
   // Table side
   input wire logic                   tbl_req,
   input wire itsdc_pkg::itsdc_tbl_t  tbl_kind,
   input wire logic [31:0]            tbl_base,
   input wire logic                   tbl_ack,
   input wire logic                   tbl_valid,
   input wire logic [31:0]            tbl_base_out,
   input wire logic [15:0]            tbl_coll,
   // Redistributor side
   input wire logic                   rd_req,
   input wire itsdc_pkg::itsdc_rdop_t rd_op,
   input wire logic [15:0]            rd_coll,
   input wire logic [31:0]            rd_intid,
   input wire logic                   rd_ack
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   ////////////////////////////////////////////////////////////
   sequence dev_rd;
      tbl_req && tbl_kind == itsdc_pkg::ITSDC_TBL_DEVICE;
   endsequence
   sequence trans_ok;
      tbl_req && tbl_kind == itsdc_pkg::ITSDC_TBL_TRANS ##1 tbl_ack && tbl_valid;
   endsequence
   sequence coll_ok;
      tbl_req && tbl_kind == itsdc_pkg::ITSDC_TBL_COLL ##1 tbl_ack && tbl_valid;
   endsequence
   ////////////////////////////////////////////////////////////
   tbl_answer_a: assert property (tbl_req |=> tbl_ack && !tbl_req)
      else $error("table request unanswered");
   rd_answer_a: assert property (rd_req |=> rd_ack && !rd_req)
      else $error("redistributor request unanswered");
   one_at_once_a: assert property (!(tbl_req && rd_req))
      else $error("table and redistributor requests overlap");
   redist_follows_a: assert property (trans_ok |=> rd_req)
      else $error("valid entry without redistributor request");
   redist_fields_a: assert property (trans_ok ##1 rd_req |-> rd_intid == $past(tbl_base_out)
         && rd_coll == $past(tbl_coll) && rd_op != itsdc_pkg::ITSDC_RD_INV_COLL)
      else $error("redistributor fields differ from entry");
   dev_error_stop_a: assert property (dev_rd ##1 tbl_ack && !tbl_valid |=> !tbl_req && !rd_req)
      else $error("walk continued past invalid device entry");
   trans_base_a: assert property (dev_rd ##1 tbl_ack && tbl_valid ##1 tbl_req
         && tbl_kind == itsdc_pkg::ITSDC_TBL_TRANS |-> tbl_base == $past(tbl_base_out))
      else $error("translation read not at device table base");
   write_after_a: assert property (tbl_req && tbl_kind == itsdc_pkg::ITSDC_TBL_TRANS_WR
         |-> $past(rd_ack) || $past(tbl_ack))
      else $error("entry write not after translation step");
   coll_refresh_a: assert property (coll_ok |=> rd_req && rd_op == itsdc_pkg::ITSDC_RD_INV_COLL)
      else $error("valid collection not refreshed");
endmodule

/* tb.sv */
// Self-checking bench: interpreter and far end joined over the link
`timescale 1ns/1ps
`include "itsdc_consts.svh"
module tb;
   logic                      REF_CLK;
   logic                      RST_N;
   logic                      CMD_VALID;
   logic [255:0]              CMD_PACKET;
   logic [15:0]               QUEUE_ENTRIES;
   logic                      CMD_TAKEN;
   logic [15:0]               QUEUE_READ_POINTER;
   logic                      STALLED;
   logic                      SYSTEM_ERROR_CAPABLE;
   itsdc_pkg::itsdc_errmode_t ERR_MODE;
   logic                      RETRY;
   logic                      SYSTEM_ERROR;
   logic                      BUSY;
   logic [3:0]                valid_by_kind;
   logic                      TBL_VALID;
   logic [4:0]                TBL_SIZE;
   logic [31:0]               TBL_DATA;
   logic [15:0]               TBL_COLL;
   logic                      TBL_VIRTUAL;
   logic                      TARGET_MAPPED;
   logic [2:0]                RD_OP_SEEN;
   logic [2:0]                last_op;
   logic [31:0]               last_intid;
   logic [15:0]               last_coll;
   logic [15:0]               exp_ptr;
   int                        err_count;
   int                        compares;
   int                        rd_cnt;
   int                        wr_cnt;
   int                        se_cnt;
   itsdc_if link_if();
   // Answer validity chosen per table kind, so one walk can fail at the device, translation or collection read
   assign TBL_VALID = valid_by_kind[link_if.tbl_kind];
   assign TBL_DATA  = 32'h0000_2340 + 32'(link_if.tbl_kind);
   itsdc_cmd_exec #(.DEV_BITS(16), .COL_BITS(8), .PTR_BITS(16)) itsdc_cmd_exec_i (
      .REF_CLK(REF_CLK), .RST_N(RST_N), .CMD_VALID(CMD_VALID), .CMD_PACKET(CMD_PACKET),
      .QUEUE_ENTRIES(QUEUE_ENTRIES), .CMD_TAKEN(CMD_TAKEN), .QUEUE_READ_POINTER(QUEUE_READ_POINTER),
      .STALLED(STALLED), .SYSTEM_ERROR_CAPABLE(SYSTEM_ERROR_CAPABLE), .ERR_MODE(ERR_MODE),
      .RETRY(RETRY), .SYSTEM_ERROR(SYSTEM_ERROR), .BUSY(BUSY), .link(link_if));
   itsdc_far_end itsdc_far_end_i (
      .REF_CLK(REF_CLK), .RST_N(RST_N), .TBL_VALID(TBL_VALID), .TBL_SIZE(TBL_SIZE),
      .TBL_DATA(TBL_DATA), .TBL_COLL(TBL_COLL), .TBL_VIRTUAL(TBL_VIRTUAL),
      .TARGET_MAPPED(TARGET_MAPPED), .TBL_SEEN(), .RD_SEEN(), .RD_OP_SEEN(RD_OP_SEEN), .link(link_if));
   itsdc_link_props itsdc_link_props_i (
      .REF_CLK(REF_CLK), .RST_N(RST_N), .tbl_req(link_if.tbl_req), .tbl_kind(link_if.tbl_kind),
      .tbl_base(link_if.tbl_base), .tbl_ack(link_if.tbl_ack), .tbl_valid(link_if.tbl_valid),
      .tbl_base_out(link_if.tbl_base_out), .tbl_coll(link_if.tbl_coll), .rd_req(link_if.rd_req),
      .rd_op(link_if.rd_op), .rd_coll(link_if.rd_coll), .rd_intid(link_if.rd_intid),
      .rd_ack(link_if.rd_ack));
   ////////////////////////////////////////////////////////////
   always #25 REF_CLK = ~REF_CLK;
   always @(posedge REF_CLK)
   begin
      if (link_if.rd_req === 1'b1)
      begin
         rd_cnt     <= rd_cnt + 1;
         last_op    <= link_if.rd_op;
         last_intid <= link_if.rd_intid;
         last_coll  <= link_if.rd_coll;
      end
      if (link_if.tbl_req === 1'b1 && link_if.tbl_kind === itsdc_pkg::ITSDC_TBL_TRANS_WR)
         wr_cnt <= wr_cnt + 1;
      if (SYSTEM_ERROR === 1'b1)
         se_cnt <= se_cnt + 1;
   end
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      compares++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD t=%0t %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic far(input logic [3:0] v, input logic [4:0] sz, input logic virt, input logic map);
      valid_by_kind = v;
      TBL_SIZE      = sz;
      TBL_VIRTUAL   = virt;
      TARGET_MAPPED = map;
   endtask
   // One packet through the walk; counts what crossed the link meanwhile
   task automatic issue(input logic [7:0] opc, input logic [31:0] dev, input logic [31:0] evt,
                        input logic [15:0] col, input int erd, input int ewr, input int ese,
                        input logic adv);
      int rd0, wr0, se0, n;
      rd0 = rd_cnt;
      wr0 = wr_cnt;
      se0 = se_cnt;
      CMD_PACKET = '0;
      CMD_PACKET[7:0] = opc;
      CMD_PACKET[63:32] = dev;
      CMD_PACKET[95:64] = evt;
      CMD_PACKET[143:128] = col;
      CMD_VALID = 1'b1;
      n = 0;
      do
      begin
         @(posedge REF_CLK);
         #1;
         n++;
      end while (CMD_TAKEN !== 1'b1 && STALLED !== 1'b1 && n < 40);
      CMD_VALID = 1'b0;
      check(CMD_TAKEN, adv, "completion");
      check(BUSY, !adv, "busy");
      if (adv)
         exp_ptr = (exp_ptr + 16'h0001) % QUEUE_ENTRIES;
      @(posedge REF_CLK);
      #1;
      check(rd_cnt - rd0, erd, "redistributor requests");
      check(wr_cnt - wr0, ewr, "entry writes");
      check(se_cnt - se0, ese, "system errors");
      check(QUEUE_READ_POINTER, exp_ptr, "read pointer");
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_good();
      far(4'b1111, 5'h04, 1'b0, 1'b1);
      issue(`ITSDC_OPC_PEND, 32'h0000_0007, 32'h0000_0003, 16'h0000, 1, 0, 0, 1'b1);
      check(last_op, itsdc_pkg::ITSDC_RD_SET, "set op");
      check(last_intid, 32'h0000_2341, "interrupt number");
      check(RD_OP_SEEN, itsdc_pkg::ITSDC_RD_SET, "far op");
      issue(`ITSDC_OPC_DROP, 32'h0000_FFFF, 32'h0000_001F, 16'h0000, 1, 1, 0, 1'b1);
      check(last_op, itsdc_pkg::ITSDC_RD_CLEAR, "clear op");
      for (int v = 0; v < 2; v++)
      begin
         far(4'b1111, 5'h04, v[0], 1'b1);
         issue(`ITSDC_OPC_EVREF, 32'h0000_0007, 32'h0000_0003, 16'h0000, 1, 0, 0, 1'b1);
         check(last_op, itsdc_pkg::ITSDC_RD_INV_EVENT, "event refresh op");
      end
      issue(`ITSDC_OPC_COLREF, 32'h0000_0000, 32'h0000_0000, 16'h00FF, 1, 0, 0, 1'b1);
      check(last_op, itsdc_pkg::ITSDC_RD_INV_COLL, "collection op");
      check(last_coll, 16'h00FF, "collection id");
   endtask
   task automatic t_errors();
      issue(`ITSDC_OPC_PEND, 32'h0001_0000, 32'h0000_0003, 16'h0000, 0, 0, 1, 1'b1);
      far(4'b1110, 5'h02, 1'b0, 1'b1);
      issue(`ITSDC_OPC_PEND, 32'h0000_0007, 32'h0000_0003, 16'h0000, 0, 0, 1, 1'b1);
      far(4'b1111, 5'h02, 1'b0, 1'b1);
      issue(`ITSDC_OPC_EVREF, 32'h0000_0007, 32'h0000_0008, 16'h0000, 0, 0, 1, 1'b1);
      issue(`ITSDC_OPC_EVREF, 32'h0000_0007, 32'h0000_0007, 16'h0000, 1, 0, 0, 1'b1);
      far(4'b1101, 5'h04, 1'b0, 1'b1);
      issue(`ITSDC_OPC_DROP, 32'h0000_0007, 32'h0000_0003, 16'h0000, 0, 1, 1, 1'b1);
      far(4'b1111, 5'h04, 1'b0, 1'b0);
      issue(`ITSDC_OPC_PEND, 32'h0000_0007, 32'h0000_0003, 16'h0000, 1, 0, 1, 1'b1);
      far(4'b1111, 5'h04, 1'b1, 1'b0);
      issue(`ITSDC_OPC_EVREF, 32'h0000_0007, 32'h0000_0003, 16'h0000, 1, 0, 1, 1'b1);
      issue(`ITSDC_OPC_COLREF, 32'h0000_0000, 32'h0000_0000, 16'h0100, 0, 0, 1, 1'b1);
      far(4'b1011, 5'h04, 1'b0, 1'b1);
      issue(`ITSDC_OPC_COLREF, 32'h0000_0000, 32'h0000_0000, 16'h0021, 0, 0, 1, 1'b1);
      SYSTEM_ERROR_CAPABLE = 1'b0;
      issue(`ITSDC_OPC_COLREF, 32'h0000_0000, 32'h0000_0000, 16'h0021, 0, 0, 0, 1'b1);
      SYSTEM_ERROR_CAPABLE = 1'b1;
      ERR_MODE = itsdc_pkg::ITSDC_ERR_EXECUTE;
      issue(`ITSDC_OPC_COLREF, 32'h0000_0000, 32'h0000_0000, 16'h0021, 0, 0, 1, 1'b1);
   endtask
   task automatic t_stall();
      ERR_MODE = itsdc_pkg::ITSDC_ERR_STALL;
      far(4'b1110, 5'h04, 1'b0, 1'b1);
      issue(`ITSDC_OPC_PEND, 32'h0000_0007, 32'h0000_0003, 16'h0000, 0, 0, 1, 1'b0);
      repeat (3) @(posedge REF_CLK);
      #1;
      check(STALLED, 1'b1, "stall held");
      far(4'b1111, 5'h04, 1'b0, 1'b1);
      RETRY = 1'b1;
      @(posedge REF_CLK);
      #1;
      RETRY = 1'b0;
      issue(`ITSDC_OPC_PEND, 32'h0000_0007, 32'h0000_0003, 16'h0000, 1, 0, 0, 1'b1);
      check(STALLED, 1'b0, "stall released");
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      REF_CLK = 1'b0;
      RST_N = 1'b0;
      CMD_VALID = 1'b0;
      CMD_PACKET = '0;
      QUEUE_ENTRIES = 16'h0003;
      SYSTEM_ERROR_CAPABLE = 1'b1;
      ERR_MODE = itsdc_pkg::ITSDC_ERR_IGNORE;
      RETRY = 1'b0;
      TBL_COLL = 16'h0005;
      far(4'b1111, 5'h04, 1'b0, 1'b1);
      {err_count, compares, rd_cnt, wr_cnt, se_cnt} = '0;
      exp_ptr = 16'h0000;
      repeat (10) @(posedge REF_CLK);
      #1;
      RST_N = 1'b1;
      t_good();
      t_errors();
      t_stall();
      final_report();
   end
   // Whole run needs well under 1000 cycles
   initial
   begin
      #1_000_000;
      err_count++;
      final_report();
   end
endmodule
